// *** src/dwlpd_pkg.sv ***
// Package for the DAC wiper latch and power-down control block.
// Assumes a 250 MHz pclk and an APB master on the register side.
`default_nettype none

package dwlpd_pkg;

	localparam int NCH = 2;
	localparam int DAC_W = 12;

	// Register byte offsets
	localparam logic [31:0] OFS_DAC0    = 32'h0000_0000;
	localparam logic [31:0] OFS_DAC1    = 32'h0000_0004;
	localparam logic [31:0] OFS_VCFG    = 32'h0000_0008;
	localparam logic [31:0] OFS_NVCFG   = 32'h0000_000c;
	localparam logic [31:0] OFS_NVDAC0  = 32'h0000_0010;
	localparam logic [31:0] OFS_NVDAC1  = 32'h0000_0014;
	localparam logic [31:0] OFS_CMD     = 32'h0000_0018;
	localparam logic [31:0] OFS_WIPER0  = 32'h0000_001c;
	localparam logic [31:0] OFS_WIPER1  = 32'h0000_0020;
	localparam logic [31:0] OFS_STATUS  = 32'h0000_0024;

	// Field positions
	localparam int CFG_W       = 5;
	localparam int CMD_GC_RST  = 0;
	localparam int CMD_GC_WAKE = 1;
	localparam int ST_HOLD     = 0;
	localparam int ST_OFF      = 1;
	localparam int ST_DRIVE    = 3;
	localparam int ST_GAINBAD  = 5;

	// Power-down selector codes
	localparam logic [1:0] PD_NORMAL = 2'h0;
	localparam logic [1:0] PD_1K     = 2'h1;
	localparam logic [1:0] PD_100K   = 2'h2;
	localparam logic [1:0] PD_OPEN   = 2'h3;

	// Reference source codes
	localparam logic [1:0] REF_VDD     = 2'h0;
	localparam logic [1:0] REF_BANDGAP = 2'h1;
	localparam logic [1:0] REF_PIN_UNB = 2'h2;
	localparam logic [1:0] REF_PIN_BUF = 2'h3;

	typedef struct packed {
		logic       output_gain_sel;
		logic [1:0] ref_source_sel;
		logic [1:0] power_down_sel;
	} dwlpd_cfg_t;

	typedef struct packed {
		logic [DAC_W-1:0] wiper;
		logic             amp_drive;
		logic             pulldown_1k;
		logic             pulldown_100k;
		logic             ladder_en;
		logic             ladder_ref_conn;
		logic             rl_amp_en;
		logic             bandgap_en;
	} dwlpd_ctl_t;

	typedef enum logic [1:0] {
		PDS_ON,
		PDS_ENTER,
		PDS_OFF,
		PDS_EXIT
	} dwlpd_pds_t;

	// Reset values
	localparam dwlpd_cfg_t       CFG_RST  = '0;
	localparam logic [DAC_W-1:0] DAC_RST  = 12'h000;
	localparam logic             HOLD_RST = 1'b1;

	// Timing
	localparam int CLK_MHZ      = 250;
	localparam int PD_ENTER_NS  = 1000;
	localparam int PD_EXIT_NS   = 2000;
	localparam int CNT_W        = 10;
	localparam logic [CNT_W-1:0] ENTER_CYC =
		CNT_W'((PD_ENTER_NS * CLK_MHZ + 999) / 1000);
	localparam logic [CNT_W-1:0] EXIT_CYC =
		CNT_W'((PD_EXIT_NS * CLK_MHZ + 999) / 1000);

endpackage : dwlpd_pkg

`default_nettype wire

// *** src/dwlpd_core.sv ***
// DAC wiper latch and per-channel power-down control, APB register slave.
// Assumes wiper_hold_n is an asynchronous pin; analog stage follows ctl.
//
// Operation
// - Hold high blocks wiper copy, writes accepted
// - Transfer is level sensitive while hold low
// - Hold low loads wiper on new value
// - Hold pin sampled independent of bus
// - Wipers on one hold pin update together
// - Two-bit selector picks output load
// - Separate power-down selector per channel
// - Power-down disables amp, ladder, keeps registers
// - Source enables follow selector and reference, bandgap_en reference only
// - Enter delay before pull-down engages
// - Exit delay before amp drives again
// - Exit re-enables circuits, drives current value
// - Write with selector 00 ends power-down
// - Wake forces 00; reset uses stored value
// - Selector changes by write, wake or reset copy
// - Only listed commands alter the selector
// - Bus stays active in every power-down
// - General reset reloads DAC and config from nonvolatile copies
`default_nettype none

module dwlpd_core
	import dwlpd_pkg::*;
(
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 ce,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [31:0]          paddr,
	input  wire logic [31:0]          pwdata,
	input  wire logic [3:0]           pstrb,
	input  wire logic                 wiper_hold_n,
	output var  logic                 pready,
	output var  logic [31:0]          prdata,
	output var  logic                 pslverr,
	output var  dwlpd_ctl_t [NCH-1:0] chan_ctl
);

	function automatic logic is_mapped(input logic [31:0] a);
		unique case (a)
			OFS_DAC0, OFS_DAC1, OFS_VCFG, OFS_NVCFG, OFS_NVDAC0,
			OFS_NVDAC1, OFS_CMD, OFS_WIPER0, OFS_WIPER1,
			OFS_STATUS: is_mapped = 1'b1;
			default:    is_mapped = 1'b0;
		endcase
	endfunction : is_mapped

	logic                  pready_q;
	logic                  pslverr_q;
	logic [31:0]           prdata_q;
	logic [2:0]            hold_sync_q;
	logic                  hold_q;
	logic [DAC_W-1:0]      dac_q    [NCH];
	logic [DAC_W-1:0]      nvdac_q  [NCH];
	dwlpd_cfg_t            vcfg_q   [NCH];
	dwlpd_cfg_t            nvcfg_q  [NCH];
	dwlpd_ctl_t            ctl_q    [NCH];
	dwlpd_pds_t            pds_q    [NCH];
	logic [CNT_W-1:0]      cnt_q    [NCH];
	logic [NCH-1:0]        off_st;
	logic [NCH-1:0]        drive_st;
	logic [NCH-1:0]        gain_bad;
	logic                  setup;
	logic                  wr_ok;
	logic                  gc_rst;
	logic                  gc_wake;
	logic [2*CFG_W-1:0]    vcfg_word;
	logic [2*CFG_W-1:0]    nvcfg_word;

	assign setup   = psel & ~penable;
	assign wr_ok   = psel & penable & pready_q & pwrite & is_mapped(paddr);
	assign gc_rst  = wr_ok & (paddr == OFS_CMD) & pwdata[CMD_GC_RST];
	assign gc_wake = wr_ok & (paddr == OFS_CMD) & pwdata[CMD_GC_WAKE];
	assign vcfg_word  = {vcfg_q[1], vcfg_q[0]};
	assign nvcfg_word = {nvcfg_q[1], nvcfg_q[0]};

	assign pready  = pready_q;
	assign prdata  = prdata_q;
	assign pslverr = pslverr_q;

	// APB answer: one-cycle access phase, registered data and error
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else if (ce) begin
			pready_q  <= setup & ~pready_q;
			pslverr_q <= setup & ~pready_q & ~is_mapped(paddr);
		end
	end

	// Read data is captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (ce) begin
			if (setup && !pwrite) begin
				unique case (paddr)
					OFS_DAC0:   prdata_q <= 32'(dac_q[0]);
					OFS_DAC1:   prdata_q <= 32'(dac_q[1]);
					OFS_VCFG:   prdata_q <= 32'(vcfg_word);
					OFS_NVCFG:  prdata_q <= 32'(nvcfg_word);
					OFS_NVDAC0: prdata_q <= 32'(nvdac_q[0]);
					OFS_NVDAC1: prdata_q <= 32'(nvdac_q[1]);
					OFS_WIPER0: prdata_q <= 32'(ctl_q[0].wiper);
					OFS_WIPER1: prdata_q <= 32'(ctl_q[1].wiper);
					OFS_STATUS: begin
						prdata_q <= 32'h0000_0000;
						prdata_q[ST_HOLD]             <= hold_q;
						prdata_q[ST_OFF +: NCH]       <= off_st;
						prdata_q[ST_DRIVE +: NCH]     <= drive_st;
						prdata_q[ST_GAINBAD +: NCH]   <= gain_bad;
					end
					default:    prdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Hold pin: three flops, a change counts once stages two and three agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_sync_q <= {3{HOLD_RST}};
			hold_q      <= HOLD_RST;
		end else if (ce) begin
			hold_sync_q <= {hold_sync_q[1:0], wiper_hold_n};
			if (hold_sync_q[1] == hold_sync_q[2]) begin
				hold_q <= hold_sync_q[2];
			end
		end
	end

	// Nonvolatile copies: only software writes change them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nvcfg_q   <= '{default: CFG_RST};
			nvdac_q   <= '{default: DAC_RST};
		end else if (ce && wr_ok) begin
			if (paddr == OFS_NVCFG) begin
				nvcfg_q[0] <= pwdata[0 +: CFG_W];
				nvcfg_q[1] <= pwdata[CFG_W +: CFG_W];
			end
			if (paddr == OFS_NVDAC0) begin
				nvdac_q[0] <= pwdata[DAC_W-1:0];
			end
			if (paddr == OFS_NVDAC1) begin
				nvdac_q[1] <= pwdata[DAC_W-1:0];
			end
		end
	end

	// Volatile DAC registers: accepted whatever the hold level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dac_q <= '{default: DAC_RST};
		end else if (ce) begin
			if (gc_rst) begin
				dac_q <= nvdac_q;
			end else if (wr_ok && paddr == OFS_DAC0) begin
				dac_q[0] <= pwdata[DAC_W-1:0];
			end else if (wr_ok && paddr == OFS_DAC1) begin
				dac_q[1] <= pwdata[DAC_W-1:0];
			end
		end
	end

	// Volatile configuration; the selector moves only on these events
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vcfg_q <= '{default: CFG_RST};
		end else if (ce) begin
			if (gc_rst) begin
				vcfg_q <= nvcfg_q;
			end else if (wr_ok && paddr == OFS_VCFG) begin
				vcfg_q[0] <= pwdata[0 +: CFG_W];
				vcfg_q[1] <= pwdata[CFG_W +: CFG_W];
			end
			if (gc_wake) begin
				vcfg_q[0].power_down_sel <= PD_NORMAL;
				vcfg_q[1].power_down_sel <= PD_NORMAL;
			end
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++) begin : g_ch
			dwlpd_cfg_t cfg;
			logic       pd_on;
			logic       powered;

			assign cfg     = vcfg_q[gi];
			assign pd_on   = cfg.power_down_sel != PD_NORMAL;
			assign powered = pds_q[gi] != PDS_OFF;
			assign off_st[gi]   = pds_q[gi] == PDS_OFF;
			assign drive_st[gi] = ctl_q[gi].amp_drive;
			assign gain_bad[gi] = cfg.output_gain_sel &
				(cfg.ref_source_sel == REF_VDD);
			assign chan_ctl[gi] = ctl_q[gi];

			// Enter and exit sequencing of the output stage
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pds_q[gi] <= PDS_ON;
					cnt_q[gi] <= '0;
				end else if (ce) begin
					unique case (pds_q[gi])
						PDS_ON: begin
							if (pd_on) begin
								pds_q[gi] <= PDS_ENTER;
								cnt_q[gi] <= ENTER_CYC - 1'b1;
							end
						end
						PDS_ENTER: begin
							if (!pd_on) begin
								pds_q[gi] <= PDS_ON;
							end else if (cnt_q[gi] == '0) begin
								pds_q[gi] <= PDS_OFF;
							end else begin
								cnt_q[gi] <= cnt_q[gi] - 1'b1;
							end
						end
						PDS_OFF: begin
							if (!pd_on) begin
								pds_q[gi] <= PDS_EXIT;
								cnt_q[gi] <= EXIT_CYC - 1'b1;
							end
						end
						PDS_EXIT: begin
							if (pd_on) begin
								pds_q[gi] <= PDS_OFF;
							end else if (cnt_q[gi] == '0) begin
								pds_q[gi] <= PDS_ON;
							end else begin
								cnt_q[gi] <= cnt_q[gi] - 1'b1;
							end
						end
					endcase
				end
			end

			// Wiper and analog enables, all registered
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					ctl_q[gi] <= '0;
				end else if (ce) begin
					if (!hold_q) begin
						ctl_q[gi].wiper <= dac_q[gi];
					end
					ctl_q[gi].amp_drive <= pds_q[gi] == PDS_ON ||
						pds_q[gi] == PDS_ENTER;
					ctl_q[gi].pulldown_1k <= !powered &&
						cfg.power_down_sel == PD_1K;
					ctl_q[gi].pulldown_100k <= !powered &&
						cfg.power_down_sel == PD_100K;
					ctl_q[gi].ladder_en <= powered &&
						cfg.ref_source_sel != REF_PIN_UNB;
					ctl_q[gi].ladder_ref_conn <= powered;
					ctl_q[gi].rl_amp_en <= powered &&
						(cfg.ref_source_sel == REF_BANDGAP ||
						cfg.ref_source_sel == REF_PIN_BUF);
					ctl_q[gi].bandgap_en <=
						cfg.ref_source_sel == REF_BANDGAP;
				end
			end
		end
	endgenerate

endmodule : dwlpd_core

`default_nettype wire

// *** testbench/dwlpd_chk_assertions.sv ***
// Checker for the control block's register port and channel controls.
// Bound into dwlpd_core; sees only its ports, ce assumed high.
`default_nettype none
module dwlpd_chk
	import dwlpd_pkg::*;
(
	input wire logic                 pclk,
	input wire logic                 presetn,
	input wire logic                 ce,
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pwrite,
	input wire logic [31:0]          paddr,
	input wire logic [31:0]          pwdata,
	input wire logic [3:0]           pstrb,
	input wire logic                 wiper_hold_n,
	input wire logic                 pready,
	input wire logic [31:0]          prdata,
	input wire logic                 pslverr,
	input wire dwlpd_ctl_t [NCH-1:0] chan_ctl
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] hi_q;
	logic [2:0] lo_q;
	logic [9:0] age_q;
	logic       acc;
	assign acc = psel && penable && pready && pwrite;
	// Consecutive samples of the hold pin at each level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hi_q <= 3'h0;
			lo_q <= 3'h0;
		end else begin
			hi_q <= !wiper_hold_n ? 3'h0 : (hi_q == 3'h7) ? 3'h7 : hi_q + 3'h1;
			lo_q <= wiper_hold_n ? 3'h0 : (lo_q == 3'h7) ? 3'h7 : lo_q + 3'h1;
		end
	end
	// Cycles since the last selector change request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			age_q <= 10'h0;
		else if (acc && (paddr == OFS_VCFG || paddr == OFS_CMD))
			age_q <= 10'h0;
		else if (age_q != 10'h3ff)
			age_q <= age_q + 10'h1;
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_setup_answer: assert property (psel && !penable && ce |=> pready)
		else $error("no answer after setup");
	a_ready_single: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_err_in_access: assert property (pslverr |-> pready && psel && penable)
		else $error("error outside access");
	a_hold_blocks: assert property (hi_q == 3'h7 |=> $stable(chan_ctl[0].wiper)
		&& $stable(chan_ctl[1].wiper))
		else $error("wiper moved while held");
	a_wiper_follows: assert property (lo_q == 3'h7 && acc && paddr == OFS_DAC0
		|-> ##2 chan_ctl[0].wiper == $past(pwdata[11:0], 2))
		else $error("wiper did not follow");
	a_enter_delay: assert property ($fell(chan_ctl[0].amp_drive)
		|-> age_q == ENTER_CYC + 10'h2)
		else $error("enter delay wrong");
	a_exit_delay: assert property ($rose(chan_ctl[0].amp_drive)
		&& $past(chan_ctl[0].ladder_en) |-> age_q == EXIT_CYC + 10'h2)
		else $error("exit delay wrong");
	a_pulldown_off: assert property (chan_ctl[0].pulldown_1k || chan_ctl[0].pulldown_100k
		|-> !chan_ctl[0].amp_drive && !chan_ctl[0].rl_amp_en && !chan_ctl[0].ladder_en
		&& !(chan_ctl[0].pulldown_1k && chan_ctl[0].pulldown_100k))
		else $error("pull-down with live output");
	cover property ($fell(chan_ctl[0].amp_drive));
	cover property (lo_q == 3'h7 && acc && paddr == OFS_DAC0);
	cover property (pslverr);
endmodule : dwlpd_chk

bind dwlpd_core dwlpd_chk u_chk (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.wiper_hold_n(wiper_hold_n), .pready(pready), .prdata(prdata), .pslverr(pslverr),
	.chan_ctl(chan_ctl));
`default_nettype wire

// *** testbench/dwlpd_apb_master.sv ***
// APB master model standing in for the bus-side controller.
// Assumes the slave answers with pready; the bench calls xfer.
`default_nettype none
module dwlpd_apb_master (
	input  wire logic        pclk,
	input  wire logic        pready,
	input  wire logic [31:0] prdata,
	input  wire logic        pslverr,
	output var  logic        psel = 1'b0,
	output var  logic        penable = 1'b0,
	output var  logic        pwrite = 1'b0,
	output var  logic [31:0] paddr = 32'h0,
	output var  logic [31:0] pwdata = 32'h0
);
	timeunit 1ns;
	timeprecision 1ps;
	// Waits for pready without a limit; the bench's cycle ceiling ends a hang
	task xfer(input logic wr, input logic [31:0] a, d, output logic [31:0] rd,
		output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released lines no longer show the old value
		paddr <= ~a;
		pwdata <= ~d;
	endtask : xfer
endmodule : dwlpd_apb_master
`default_nettype wire

// *** testbench/testbench.sv ***
// Self-checking bench for the wiper latch and power-down block.
// Assumes the APB master model and the bound checker.
`default_nettype none
module testbench import dwlpd_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic                 pclk;
	logic                 presetn;
	logic                 hold_n;
	logic                 psel;
	logic                 penable;
	logic                 pwrite;
	logic                 pready;
	logic                 pslverr;
	logic [31:0]          paddr;
	logic [31:0]          pwdata;
	logic [31:0]          prdata;
	dwlpd_ctl_t [NCH-1:0] ctl;
	int                   fails;
	int                   compares;
	int                   cyc;
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	dwlpd_apb_master u_mst (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
	dwlpd_core u_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
		.wiper_hold_n(hold_n), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.chan_ctl(ctl));
	task summarize;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : summarize
	task chk(input logic [31:0] got, exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [31:0] a, d);
		logic [31:0] r;
		logic        e;
		u_mst.xfer(1'b1, a, d, r, e);
	endtask : wr
	// Addresses above the last register must be refused
	task rd_chk(input logic [31:0] a, exp);
		logic [31:0] r;
		logic        e;
		u_mst.xfer(1'b0, a, 32'h0, r, e);
		chk(r, exp);
		chk(32'(e), 32'(a > OFS_STATUS));
	endtask : rd_chk
	task cycles(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask : cycles
	task measure(input logic lvl, output int n);
		n = 0;
		do begin
			@(posedge pclk);
			#1;
			n++;
		end while (ctl[0].amp_drive !== lvl && n < 1000);
	endtask : measure
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			summarize();
		end
	end
	initial begin
		int n;
		presetn = 1'b0;
		hold_n = 1'b1;
		fails = 0;
		compares = 0;
		cyc = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(OFS_VCFG, 32'h0);
		rd_chk(OFS_DAC0, 32'h0);
		rd_chk(OFS_STATUS, 32'h19);
		rd_chk(32'h28, 32'h0);
		$display("test reset done");
		wr(OFS_DAC0, 32'habc);
		wr(OFS_DAC1, 32'h123);
		cycles(8);
		chk(32'({ctl[1].wiper, ctl[0].wiper}), 32'h0);
		rd_chk(OFS_DAC1, 32'h123);
		@(posedge pclk);
		hold_n <= 1'b0;
		cycles(10);
		chk(32'({ctl[1].wiper, ctl[0].wiper}), 32'h123abc);
		wr(OFS_DAC0, 32'h5a5);
		cycles(2);
		chk(32'(ctl[0].wiper), 32'h5a5);
		rd_chk(OFS_WIPER0, 32'h5a5);
		$display("test latch done");
		wr(OFS_VCFG, 32'h1);
		measure(1'b0, n);
		chk(32'(n), 32'(ENTER_CYC) + 32'h2);
		chk(32'({ctl[0].pulldown_1k, ctl[0].ladder_en, ctl[1].amp_drive}), 32'h5);
		rd_chk(OFS_DAC0, 32'h5a5);
		for (int c = 2; c < 4; c++) begin
			wr(OFS_VCFG, 32'(c));
			cycles(3);
			chk(32'({ctl[0].pulldown_1k, ctl[0].pulldown_100k}), 32'(c == 2));
		end
		wr(OFS_VCFG, 32'h0);
		measure(1'b1, n);
		chk(32'(n), 32'(EXIT_CYC) + 32'h2);
		chk(32'({ctl[0].pulldown_100k, ctl[0].ladder_ref_conn}), 32'h1);
		wr(OFS_VCFG, 32'h4);
		cycles(3);
		chk(32'({ctl[0].rl_amp_en, ctl[0].bandgap_en, ctl[0].amp_drive}), 32'h7);
		// Unbuffered pin reference with gain 2x: ladder fed from the pin, not the supply
		wr(OFS_VCFG, 32'h18);
		cycles(3);
		chk(32'({ctl[0].ladder_en, ctl[0].rl_amp_en, ctl[0].amp_drive}), 32'h1);
		// Gain 2x on the supply reference is flagged in status
		wr(OFS_VCFG, 32'h10);
		rd_chk(OFS_STATUS, 32'h38);
		$display("test power-down done");
		wr(OFS_NVCFG, 32'h3);
		wr(OFS_CMD, 32'h1);
		rd_chk(OFS_VCFG, 32'h3);
		rd_chk(OFS_DAC0, 32'h0);
		wr(OFS_CMD, 32'h2);
		rd_chk(OFS_VCFG, 32'h0);
		$display("test commands done");
		summarize();
	end
endmodule : testbench
`default_nettype wire
